// file: logic/status_unit_pkg.sv
package status_unit_pkg;

  // ---------------------------------------------------------------
  // remote commands
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    CMD_SETTING_LOAD,
    CMD_SETTING_SAVE,
    CMD_SETTING_WRITE,
    CMD_RESET,
    CMD_TRIGGER,
    CMD_CLEAR_STATUS,
    CMD_IDENT_Q,
    CMD_SELFTEST_Q,
    CMD_EVENT_EN_W,
    CMD_EVENT_EN_Q,
    CMD_SRQ_EN_W,
    CMD_SRQ_EN_Q,
    CMD_EVENT_Q,
    CMD_STATUS_Q,
    CMD_OP_DONE,
    CMD_OP_DONE_Q
  } cmd_t;

  // ---------------------------------------------------------------
  // setting files
  // ---------------------------------------------------------------
  localparam int FILE_COUNT = 10;
  localparam logic [15:0] SETTING_DEFAULT = 16'h0000;

  // ---------------------------------------------------------------
  // standard event status fields
  // ---------------------------------------------------------------
  localparam int EV_POWER_ON = 7;
  localparam int EV_USER_REQ = 6;
  localparam int EV_CMD_ERR = 5;
  localparam int EV_EXEC_ERR = 4;
  localparam int EV_DEV_ERR = 3;
  localparam int EV_QUERY_ERR = 2;
  localparam int EV_REQ_CTRL = 1;
  localparam int EV_OP_DONE = 0;
  localparam logic [7:0] EVENT_RESET = 8'h80;
  localparam logic [7:0] EVENT_EN_RESET = 8'h00;
  localparam logic [7:0] SRQ_EN_RESET = 8'h00;

  // ---------------------------------------------------------------
  // status byte fields
  // ---------------------------------------------------------------
  localparam int SB_OPER = 7;
  localparam int SB_RQS = 6;
  localparam int SB_EVENT = 5;
  localparam int SB_MAV = 4;
  localparam logic [7:0] SB_RQS_MASK = 8'h40;

  // ---------------------------------------------------------------
  // reply text
  // ---------------------------------------------------------------
  localparam logic [7:0] CHAR_NL = 8'h0A;
  localparam logic [7:0] CHAR_ZERO = 8'h30;
  localparam logic [15:0] OP_DONE_REPLY = 16'h0001;
  localparam int NUM_DIGITS = 5;
  localparam int IDN_LEN = 16;
  // identity text is arbitrary
  localparam logic [8*IDN_LEN-1:0] IDN_TEXT = "ANYMAKER,LCR1,V1";

endpackage : status_unit_pkg

// file: logic/setting_store_if.sv
interface setting_store_if #(
  parameter int SW = 16
);
  logic req;
  logic write;
  logic [3:0] index;
  logic [SW-1:0] wdata;
  logic [SW-1:0] rdata;
  logic hit;
  logic done;

  modport client (output req, write, index, wdata, input rdata, hit, done);
  modport store (input req, write, index, wdata, output rdata, hit, done);
endinterface : setting_store_if

// file: logic/setting_store.sv
module setting_store #(
  parameter int SW = 16,
  parameter int FILES = 10
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // access port
  setting_store_if.store port
);
  logic [SW-1:0] mem [FILES];
  logic [FILES-1:0] saved_reg;

  initial begin
    if (FILES < 1 || FILES > 16) begin
      $error("setting_store: FILES must be 1 to 16");
    end
  end

  // ---------------------------------------------------------------
  // file array, one access per request
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (port.req && port.write) begin
      mem[port.index] <= port.wdata;
    end
    if (port.req) begin
      port.rdata <= mem[port.index];
    end
  end

  // a file never saved reads as a miss
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      saved_reg <= '0;
      port.done <= 1'b0;
      port.hit <= 1'b0;
    end else begin
      port.done <= port.req;
      if (port.req) begin
        port.hit <= port.write | saved_reg[port.index];
      end
      if (port.req && port.write) begin
        saved_reg[port.index] <= 1'b1;
      end
    end
  end

  property p_done_follows;
    @(posedge clk) disable iff (sys_rst) port.req |=> port.done;
  endproperty
  a_done_follows: assert property (p_done_follows) else $error("store done missing");

endmodule : setting_store

// file: logic/common_command_status_unit.sv
// Behaviour
// - a load command with file index 0 to 9 restores the setting saved under that index.
// - a save command with file index 0 to 9 stores the whole current setting under it.
// - the reset command returns the instrument setting to its default state.
// - the trigger command starts one measurement and queues its result as the reply.
// - the clear-status command zeroes the event status register and so the event summary bit.
// - the identity query replies maker, model and firmware separated by commas, then newline.
// - the self-test query runs the self-check and replies the error count, zero for none.
// - the event enable command loads an 8-bit mask and its query returns that mask.
// - event status bits 7 to 0 are power-on, user, command, execution, device, query, control, done.
// - the service request enable command loads an 8-bit mask and its query returns it.
// - status byte bits are operation summary, request service, event summary, message available, 3-0 zero.
// - the event status query replies the register content in decimal.
// - the status byte query replies the status byte in decimal and leaves it unchanged.
// - the operation complete command sets event bit 0 once pending work is finished.
// - the operation complete query replies character one once pending work is finished.
module common_command_status_unit
  import status_unit_pkg::*;
#(
  parameter int SETTING_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // decoded commands from the remote controller
  input wire logic cmd_valid,
  input wire status_unit_pkg::cmd_t cmd_code,
  input wire logic [15:0] cmd_arg,
  output logic cmd_ready,
  // reply characters to the controller
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  input wire logic rsp_ready,
  // measurement engine
  output logic meas_start,
  input wire logic meas_done,
  input wire logic [15:0] meas_result,
  // self-check engine
  output logic self_test_start,
  input wire logic self_test_done,
  input wire logic [7:0] self_test_errors,
  // instrument events
  input wire logic user_request,
  input wire logic device_error,
  input wire logic oper_summary,
  // status and setting
  output logic [7:0] status_byte,
  output logic service_request,
  output logic [SETTING_W-1:0] setting,
  output logic instrument_reset
);
  import status_unit_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_STORE, ST_MEAS, ST_TEST, ST_REPLY} state_t;

  initial begin
    if (SETTING_W < 1 || SETTING_W > 16) begin
      $error("SETTING_W must be 1 to 16");
    end
  end

  setting_store_if #(.SW(SETTING_W)) st ();

  setting_store #(.SW(SETTING_W), .FILES(FILE_COUNT)) u_store (
    .clk(clk),
    .sys_rst(sys_rst),
    .port(st.store)
  );

  state_t state_reg;
  logic cmd_ready_reg;
  logic rsp_valid_reg;
  logic [7:0] rsp_data_reg;
  logic meas_start_reg;
  logic test_start_reg;
  logic [7:0] event_reg;
  logic [7:0] event_en_reg;
  logic [7:0] srq_en_reg;
  logic [7:0] status_reg;
  logic srq_reg;
  logic [SETTING_W-1:0] setting_reg;
  logic inst_reset_reg;
  logic req_reg;
  logic write_reg;
  logic [3:0] index_reg;
  logic [SETTING_W-1:0] wdata_reg;
  logic ident_reg;
  logic lead_reg;
  logic nl_sent_reg;
  logic [4:0] pos_reg;
  logic [15:0] num_reg;

  logic take;
  logic idx_ok;
  logic byte_ok;
  logic cmd_err;
  logic exec_err;
  logic op_done_ev;
  logic event_clr;
  logic [7:0] event_set;
  logic event_sum;
  logic rqs;
  logic send;
  logic [4:0] reply_len;
  logic [3:0] digit;
  logic [7:0] reply_char;

  assign cmd_ready = cmd_ready_reg;
  assign rsp_valid = rsp_valid_reg;
  assign rsp_data = rsp_data_reg;
  assign meas_start = meas_start_reg;
  assign self_test_start = test_start_reg;
  assign status_byte = status_reg;
  assign service_request = srq_reg;
  assign setting = setting_reg;
  assign instrument_reset = inst_reset_reg;
  assign st.req = req_reg;
  assign st.write = write_reg;
  assign st.index = index_reg;
  assign st.wdata = wdata_reg;

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  function automatic logic [3:0] dec_digit(input logic [15:0] v, input logic [4:0] p);
    logic [15:0] q;
    case (p)
      5'd0: q = v / 16'd10000;
      5'd1: q = v / 16'd1000;
      5'd2: q = v / 16'd100;
      5'd3: q = v / 16'd10;
      default: q = v;
    endcase
    return 4'(q % 16'd10);
  endfunction : dec_digit

  // commands are only taken while idle, so every earlier one has finished
  assign take = cmd_valid && cmd_ready_reg;
  assign idx_ok = cmd_arg < 16'(FILE_COUNT);
  assign byte_ok = cmd_arg[15:8] == 8'h00;

  // error and completion events of the accepted command
  always_comb begin
    cmd_err = 1'b0;
    exec_err = 1'b0;
    op_done_ev = 1'b0;
    if (take) begin
      case (cmd_code)
        CMD_SETTING_LOAD, CMD_SETTING_SAVE: exec_err = !idx_ok;
        CMD_EVENT_EN_W, CMD_SRQ_EN_W: exec_err = !byte_ok;
        CMD_OP_DONE: op_done_ev = 1'b1;
        CMD_SETTING_WRITE, CMD_RESET, CMD_TRIGGER, CMD_CLEAR_STATUS, CMD_IDENT_Q,
        CMD_SELFTEST_Q, CMD_EVENT_EN_Q, CMD_SRQ_EN_Q, CMD_EVENT_Q, CMD_STATUS_Q,
        CMD_OP_DONE_Q: cmd_err = 1'b0;
        default: cmd_err = 1'b1;
      endcase
    end
    // loading a file never saved is an execution error
    if (state_reg == ST_STORE && st.done && !write_reg && !st.hit) begin
      exec_err = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // event status register
  // ---------------------------------------------------------------
  // event bit layout
  always_comb begin
    event_set = 8'h00;
    event_set[EV_USER_REQ] = user_request;
    event_set[EV_CMD_ERR] = cmd_err;
    event_set[EV_EXEC_ERR] = exec_err;
    event_set[EV_DEV_ERR] = device_error;
    event_set[EV_OP_DONE] = op_done_ev;
  end

  assign event_clr = take && (cmd_code == CMD_CLEAR_STATUS || cmd_code == CMD_EVENT_Q);

  // read of the register clears it too; a new event in that cycle still lands
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      event_reg <= EVENT_RESET;
    end else begin
      event_reg <= (event_clr ? 8'h00 : event_reg) | event_set;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      event_en_reg <= EVENT_EN_RESET;
    end else if (take && cmd_code == CMD_EVENT_EN_W && byte_ok) begin
      event_en_reg <= cmd_arg[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      srq_en_reg <= SRQ_EN_RESET;
    end else if (take && cmd_code == CMD_SRQ_EN_W && byte_ok) begin
      srq_en_reg <= cmd_arg[7:0];
    end
  end

  // ---------------------------------------------------------------
  // status byte and service request
  // ---------------------------------------------------------------
  // event summary
  assign event_sum = |(event_reg & event_en_reg);
  assign rqs = |({oper_summary, 1'b0, event_sum, rsp_valid_reg, 4'h0} & srq_en_reg & ~SB_RQS_MASK);

  // status byte layout, low nibble zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      status_reg <= 8'h00;
      srq_reg <= 1'b0;
    end else begin
      status_reg <= 8'h00;
      status_reg[SB_OPER] <= oper_summary;
      status_reg[SB_RQS] <= rqs;
      status_reg[SB_EVENT] <= event_sum;
      status_reg[SB_MAV] <= rsp_valid_reg;
      srq_reg <= rqs;
    end
  end

  // ---------------------------------------------------------------
  // instrument setting
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      setting_reg <= SETTING_W'(SETTING_DEFAULT);
      inst_reset_reg <= 1'b0;
    end else begin
      inst_reset_reg <= take && cmd_code == CMD_RESET;
      if (take && cmd_code == CMD_RESET) begin
        setting_reg <= SETTING_W'(SETTING_DEFAULT);
      end else if (take && cmd_code == CMD_SETTING_WRITE) begin
        setting_reg <= cmd_arg[SETTING_W-1:0];
      end else if (state_reg == ST_STORE && st.done && !write_reg && st.hit) begin
        setting_reg <= st.rdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // reply character generation
  // ---------------------------------------------------------------
  assign send = !rsp_valid_reg || rsp_ready;
  assign reply_len = ident_reg ? 5'(IDN_LEN) : 5'(NUM_DIGITS);
  assign digit = dec_digit(num_reg, pos_reg);

  always_comb begin
    if (ident_reg) begin
      reply_char = IDN_TEXT[8*(IDN_LEN-1-int'(pos_reg)) +: 8];
    end else begin
      reply_char = CHAR_ZERO + {4'h0, digit};
    end
  end

  // ---------------------------------------------------------------
  // command sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      cmd_ready_reg <= 1'b0;
      rsp_valid_reg <= 1'b0;
      rsp_data_reg <= 8'h00;
      meas_start_reg <= 1'b0;
      test_start_reg <= 1'b0;
      req_reg <= 1'b0;
      write_reg <= 1'b0;
      index_reg <= 4'h0;
      wdata_reg <= '0;
      ident_reg <= 1'b0;
      lead_reg <= 1'b0;
      nl_sent_reg <= 1'b0;
      pos_reg <= 5'd0;
      num_reg <= 16'h0000;
    end else begin
      meas_start_reg <= 1'b0;
      test_start_reg <= 1'b0;
      req_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          cmd_ready_reg <= 1'b1;
          ident_reg <= 1'b0;
          lead_reg <= 1'b1;
          nl_sent_reg <= 1'b0;
          pos_reg <= 5'd0;
          if (take) begin
            case (cmd_code)
              CMD_SETTING_LOAD, CMD_SETTING_SAVE: begin
                if (idx_ok) begin
                  req_reg <= 1'b1;
                  write_reg <= cmd_code == CMD_SETTING_SAVE;
                  index_reg <= cmd_arg[3:0];
                  wdata_reg <= setting_reg;
                  cmd_ready_reg <= 1'b0;
                  state_reg <= ST_STORE;
                end
              end
              CMD_TRIGGER: begin
                meas_start_reg <= 1'b1;
                cmd_ready_reg <= 1'b0;
                state_reg <= ST_MEAS;
              end
              CMD_SELFTEST_Q: begin
                test_start_reg <= 1'b1;
                cmd_ready_reg <= 1'b0;
                state_reg <= ST_TEST;
              end
              CMD_IDENT_Q: begin
                ident_reg <= 1'b1;
                cmd_ready_reg <= 1'b0;
                state_reg <= ST_REPLY;
              end
              CMD_EVENT_EN_Q, CMD_SRQ_EN_Q, CMD_EVENT_Q, CMD_STATUS_Q, CMD_OP_DONE_Q: begin
                cmd_ready_reg <= 1'b0;
                state_reg <= ST_REPLY;
              end
              default: state_reg <= ST_IDLE;
            endcase
            // reply value of each query; status byte read only
            case (cmd_code)
              CMD_EVENT_EN_Q: num_reg <= {8'h00, event_en_reg};
              CMD_SRQ_EN_Q: num_reg <= {8'h00, srq_en_reg};
              CMD_EVENT_Q: num_reg <= {8'h00, event_reg};
              CMD_STATUS_Q: num_reg <= {8'h00, status_reg};
              CMD_OP_DONE_Q: num_reg <= OP_DONE_REPLY;
              default: num_reg <= num_reg;
            endcase
          end
        end
        ST_STORE: begin
          if (st.done) begin
            cmd_ready_reg <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        ST_MEAS: begin
          if (meas_done) begin
            num_reg <= meas_result;
            state_reg <= ST_REPLY;
          end
        end
        ST_TEST: begin
          if (self_test_done) begin
            num_reg <= {8'h00, self_test_errors};
            state_reg <= ST_REPLY;
          end
        end
        ST_REPLY: begin
          if (send) begin
            if (nl_sent_reg) begin
              rsp_valid_reg <= 1'b0;
              cmd_ready_reg <= 1'b1;
              state_reg <= ST_IDLE;
            end else if (pos_reg == reply_len) begin
              rsp_data_reg <= CHAR_NL;
              rsp_valid_reg <= 1'b1;
              nl_sent_reg <= 1'b1;
            end else if (!ident_reg && lead_reg && pos_reg != 5'(NUM_DIGITS - 1)
                && digit == 4'h0) begin
              // leading zeros are skipped, the last digit always goes
              pos_reg <= pos_reg + 5'd1;
            end else begin
              rsp_data_reg <= reply_char;
              rsp_valid_reg <= 1'b1;
              lead_reg <= 1'b0;
              pos_reg <= pos_reg + 5'd1;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_take(cmd_t c);
    take && cmd_code == c;
  endsequence

  property p_load_restore;
    state_reg == ST_STORE && st.done && !write_reg && st.hit |=> setting_reg == $past(st.rdata);
  endproperty
  a_load_restore: assert property (p_load_restore) else $error("load did not restore");

  property p_save_req;
    s_take(CMD_SETTING_SAVE) and idx_ok |=> req_reg && write_reg && wdata_reg == $past(setting_reg);
  endproperty
  a_save_req: assert property (p_save_req) else $error("save not issued");

  property p_reset_default;
    s_take(CMD_RESET) |=> setting_reg == SETTING_W'(SETTING_DEFAULT) && inst_reset_reg;
  endproperty
  a_reset_default: assert property (p_reset_default) else $error("reset left setting");

  property p_trigger;
    s_take(CMD_TRIGGER) |=> meas_start_reg ##1 !meas_start_reg;
  endproperty
  a_trigger: assert property (p_trigger) else $error("trigger pulse wrong");

  property p_clear;
    s_take(CMD_CLEAR_STATUS) and event_set == 8'h00 |=> event_reg == 8'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("clear left events");

  property p_ident_first;
    s_take(CMD_IDENT_Q) |=> ##1 rsp_valid_reg && rsp_data_reg == IDN_TEXT[8*IDN_LEN-1 -: 8];
  endproperty
  a_ident_first: assert property (p_ident_first) else $error("identity text wrong");

  property p_event_en;
    s_take(CMD_EVENT_EN_W) and byte_ok |=> event_en_reg == $past(cmd_arg[7:0]);
  endproperty
  a_event_en: assert property (p_event_en) else $error("event mask not loaded");

  property p_low_zero;
    status_reg[3:0] == 4'h0;
  endproperty
  a_low_zero: assert property (p_low_zero) else $error("status low bits set");

  property p_summary;
    ##1 status_reg[SB_EVENT] == $past(event_sum);
  endproperty
  a_summary: assert property (p_summary) else $error("event summary wrong");

  property p_rqs;
    ##1 srq_reg == |(status_reg & $past(srq_en_reg) & ~SB_RQS_MASK);
  endproperty
  a_rqs: assert property (p_rqs) else $error("request service wrong");

  property p_op_done;
    s_take(CMD_OP_DONE) |=> event_reg[EV_OP_DONE];
  endproperty
  a_op_done: assert property (p_op_done) else $error("done bit not set");

  property p_op_query;
    s_take(CMD_OP_DONE_Q) |=> ##5 rsp_valid_reg && rsp_data_reg == 8'h31;
  endproperty
  a_op_query: assert property (p_op_query) else $error("done query wrong");

endmodule : common_command_status_unit

// file: bench/engine_model.sv
// measurement and self-check engines seen from the unit's far side
module engine_model (
  // clock
  input wire logic clk,
  // measurement engine
  input wire logic meas_start,
  output logic meas_done,
  output logic [15:0] meas_result,
  output logic [15:0] last_meas,
  // self-check engine
  input wire logic self_test_start,
  output logic self_test_done,
  output logic [7:0] self_test_errors,
  input wire logic [7:0] err_val
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle outputs at time zero
  initial begin
    meas_done = 1'b0;
    self_test_done = 1'b0;
    meas_result = 16'h0000;
    last_meas = 16'h0000;
    self_test_errors = 8'h00;
  end

  // one result per start
  // result only valid with the done pulse, inverted after so stale reads show
  initial forever begin
    @(posedge clk);
    if (meas_start === 1'b1) begin
      repeat ($urandom_range(1, 8)) @(negedge clk);
      last_meas = 16'($urandom);
      meas_result = last_meas;
      meas_done = 1'b1;
      @(negedge clk);
      meas_done = 1'b0;
      meas_result = ~last_meas;
    end
  end

  initial forever begin
    @(posedge clk);
    if (self_test_start === 1'b1) begin
      repeat ($urandom_range(1, 8)) @(negedge clk);
      self_test_errors = err_val;
      self_test_done = 1'b1;
      @(negedge clk);
      self_test_done = 1'b0;
      self_test_errors = ~err_val;
    end
  end
endmodule : engine_model

// file: bench/common_command_status_unit_tb.sv
module common_command_status_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import status_unit_pkg::*;
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected at %0t: %0h not %0h", $time, g, e); end end

  logic clk, sys_rst, cmd_valid, cmd_ready, rsp_valid, rsp_ready, meas_start, meas_done;
  logic self_test_start, self_test_done, user_request, device_error, oper_summary;
  logic service_request, instrument_reset;
  logic [15:0] cmd_arg, meas_result, setting, last_meas;
  logic [7:0] rsp_data, self_test_errors, status_byte, err_val, rst_seen;
  logic [15:0] saved [10];
  logic [159:0] r;
  cmd_t cmd_code;
  int num_errors, samples_checked, i, k;

  common_command_status_unit #(.SETTING_W(16)) common_command_status_unit_i (.clk(clk),
    .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_arg(cmd_arg),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ready(rsp_ready),
    .meas_start(meas_start), .meas_done(meas_done), .meas_result(meas_result),
    .self_test_start(self_test_start), .self_test_done(self_test_done),
    .self_test_errors(self_test_errors), .user_request(user_request),
    .device_error(device_error), .oper_summary(oper_summary), .status_byte(status_byte),
    .service_request(service_request), .setting(setting), .instrument_reset(instrument_reset));

  engine_model engine_model_i (.clk(clk), .meas_start(meas_start), .meas_done(meas_done),
    .meas_result(meas_result), .last_meas(last_meas), .self_test_start(self_test_start),
    .self_test_done(self_test_done), .self_test_errors(self_test_errors), .err_val(err_val));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // 8 ns clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // count reset pulses on the sampled value
  always @(posedge clk) begin
    if (instrument_reset === 1'b1) rst_seen <= rst_seen + 8'h01;
  end

  // decimal text packed right-aligned, as the unit sends it
  function automatic logic [159:0] dec(int v);
    logic [159:0] t;
    int n;
    t = '0;
    n = 0;
    do begin
      t[8*n+:8] = 8'(48 + v % 10);
      v = v / 10;
      n++;
    end while (v > 0);
    return t;
  endfunction : dec

  task automatic results;
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results

  task automatic hang;
    num_errors++;
    $display("unexpected at %0t: wait limit", $time);
    results();
  endtask : hang

  // hold the command until an edge sees ready, then release a cycle later
  task automatic send(input cmd_t c, input logic [15:0] a);
    int n;
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_arg = a;
    for (n = 0; n < 300 && cmd_ready !== 1'b1; n++) @(negedge clk);
    if (n == 300) hang();
    @(negedge clk);
    cmd_valid = 1'b0;
    @(negedge clk);
  endtask : send

  task automatic wait_idle;
    int n;
    for (n = 0; n < 300 && cmd_ready !== 1'b1; n++) @(negedge clk);
    if (n == 300) hang();
  endtask : wait_idle

  // collect reply text up to newline while stalling at random
  task automatic get_reply(output logic [159:0] t);
    int n;
    t = '0;
    for (n = 0; n < 400; n++) begin
      @(negedge clk);
      rsp_ready = 1'($urandom);
      if (rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
        // newline goes, then ready drops so no later character slips by unseen;
        // one more cycle lets the lagging message-available bit settle
        if (rsp_data === CHAR_NL) begin
          @(negedge clk);
          rsp_ready = 1'b0;
          @(negedge clk);
          return;
        end
        t = {t[151:0], rsp_data};
      end
    end
    hang();
  endtask : get_reply

  task automatic q(input cmd_t c, input logic [15:0] a, input logic [159:0] e);
    logic [159:0] t;
    send(c, a);
    get_reply(t);
    `CHK(t, e)
  endtask : q

  task automatic pulse_events;
    user_request = 1'b1;
    device_error = 1'b1;
    @(negedge clk);
    user_request = 1'b0;
    device_error = 1'b0;
    repeat (3) @(negedge clk);
  endtask : pulse_events

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {sys_rst, cmd_valid, user_request, device_error, oper_summary} = 5'h10;
    {cmd_arg, rsp_ready, err_val, rst_seen} = '0;
    cmd_code = CMD_RESET;
    void'($urandom(10));
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    q(CMD_EVENT_Q, 16'h0000, dec(128));
    q(CMD_EVENT_Q, 16'h0000, dec(0));
    q(CMD_STATUS_Q, 16'h0000, dec(0));
    $display("test power-on done");
    for (k = 0; k < 6; k++) begin
      i = (k == 0) ? 0 : (k == 1) ? 255 : $urandom_range(0, 255);
      send(CMD_EVENT_EN_W, 16'(i));
      q(CMD_EVENT_EN_Q, 16'h0000, dec(i));
      send(CMD_SRQ_EN_W, 16'(i));
      q(CMD_SRQ_EN_Q, 16'h0000, dec(i));
    end
    send(CMD_EVENT_EN_W, 16'h0100);
    q(CMD_EVENT_Q, 16'h0000, dec(16));
    $display("test masks done");
    send(CMD_EVENT_EN_W, 16'h0008);
    send(CMD_SRQ_EN_W, 16'h0020);
    oper_summary = 1'b1;
    pulse_events();
    `CHK({status_byte, service_request}, 9'h1C1)
    q(CMD_STATUS_Q, 16'h0000, dec(224));
    q(CMD_STATUS_Q, 16'h0000, dec(224));
    send(CMD_CLEAR_STATUS, 16'h0000);
    repeat (3) @(negedge clk);
    `CHK({status_byte, service_request}, 9'h100)
    send(CMD_SRQ_EN_W, 16'h0080);
    repeat (3) @(negedge clk);
    `CHK(service_request, 1'b1)
    pulse_events();
    q(CMD_EVENT_Q, 16'h0000, dec(72));
    $display("test status done");
    send(CMD_SETTING_LOAD, 16'h0003);
    wait_idle();
    q(CMD_EVENT_Q, 16'h0000, dec(16));
    for (i = 0; i < FILE_COUNT; i++) begin
      saved[i] = 16'($urandom);
      send(CMD_SETTING_WRITE, saved[i]);
      send(CMD_SETTING_SAVE, 16'(i));
      wait_idle();
    end
    for (k = 0; k < FILE_COUNT; k++) begin
      send(CMD_SETTING_LOAD, 16'(9 - k));
      wait_idle();
      `CHK(setting, saved[9 - k])
    end
    send(CMD_SETTING_LOAD, 16'h000A);
    send(CMD_SETTING_SAVE, 16'h000F);
    wait_idle();
    `CHK(setting, saved[0])
    q(CMD_EVENT_Q, 16'h0000, dec(16));
    send(CMD_RESET, 16'h0000);
    repeat (2) @(negedge clk);
    `CHK({setting, rst_seen}, {SETTING_DEFAULT, 8'h01})
    $display("test settings done");
    for (k = 0; k < 3; k++) begin
      send(CMD_TRIGGER, 16'h0000);
      get_reply(r);
      `CHK(r, dec(int'(last_meas)))
    end
    err_val = 8'h00;
    q(CMD_SELFTEST_Q, 16'h0000, dec(0));
    err_val = 8'($urandom_range(1, 255));
    q(CMD_SELFTEST_Q, 16'h0000, dec(int'(err_val)));
    $display("test engines done");
    q(CMD_IDENT_Q, 16'h0000, 160'(IDN_TEXT));
    q(CMD_OP_DONE_Q, 16'h0000, 160'(8'h31));
    send(CMD_OP_DONE, 16'h0000);
    repeat (2) @(negedge clk);
    q(CMD_EVENT_Q, 16'h0000, dec(1));
    send(cmd_t'(5'h1F), 16'h0000);
    q(CMD_EVENT_Q, 16'h0000, dec(32));
    $display("test replies done");
    results();
  end
endmodule : common_command_status_unit_tb
